// ### rtl/fbs_slave_ctrl.sv
// Fieldbus slave state control: parses passing frames, serves datagrams,
// updates working counters, runs the state machine and output watchdog.
// Assumes a byte stream from the receive port and a sink toward the next port.
//
// Contract
// - Auto-increment datagrams address the slave by chain position.
// - Fixed datagrams address the slave by its programmed node address.
// - Frame is preamble, Ethernet header, bus header, datagrams, checksum.
// - A frame holds one or more datagrams, raw or inside UDP over IP.
// - Working counter rises only when addressed and data were exchanged.
// - Four sync manager channels guard consistent memory regions.
// - Output watchdog expiry signals timeout and drops Operational to Safe-operational.
// - Fault reaction follows a flag: motor passive or velocity zero.
// - Missing output updates are the only sign of a lost master.
// - Start in Init; change state only on master request; watchdog expiry also drops Operational to Safe-operational.
// - Bootstrap state is not supported.
// - Init allows no mailbox and no process data.
// - Pre-operational allows mailbox access but no process data.
// - Safe-operational sends inputs but accepts no outputs.
// - Operational sends inputs and acts on received outputs.
// - Faults in module or drive raise an emergency message.
`timescale 1ns/1ps
`include "fbs_cfg.svh"
module fbs_slave_ctrl #(
   parameter int unsigned WD_CYCLES = `FBS_WD_TIME_MS * `FBS_CLK_KHZ
) (
   // Clock and reset
   input  wire logic            core_clk,
   input  wire logic            srst,
   // Frame in
   input  wire logic [7:0]      rx_data,
   input  wire logic            rx_valid,
   input  wire logic            rx_first,
   input  wire logic            rx_last,
   output logic                 rx_ready,
   // Frame out
   output logic [7:0]           tx_data,
   output logic                 tx_last,
   output logic                 tx_valid,
   input  wire logic            tx_ready,
   // Station
   input  wire logic [15:0]     node_addr,
   // Application memory
   input  wire logic [8:0]      app_addr,
   input  wire logic            app_we,
   input  wire logic [7:0]      app_wdata,
   output logic [7:0]           app_rdata,
   // Drive and fault handling
   input  wire logic            fault_zero_vel,
   input  wire logic            drive_fault,
   output logic                 motor_passive,
   output logic                 motor_zero_vel,
   output logic                 wd_timeout,
   output logic                 emcy_valid,
   output logic [15:0]          emcy_code,
   // Events and state
   output logic                 out_update,
   output logic                 mbx_rx,
   output fbs_pkg::fbs_al_t     al_state
);
   import fbs_pkg::*;

   fbs_parse_t  ps;
   fbs_parse_t  next_ps;
   logic [10:0] cnt;
   logic [10:0] lim;
   logic [7:0]  etype_hi;
   logic [7:0]  cmd;
   logic [7:0]  adp_lo;
   logic [15:0] ado;
   logic [10:0] dlen;
   logic        more;
   logic        hit;
   logic        exch;
   logic        carry;
   logic        wr_mbx;
   logic        wr_pd;
   logic        s_valid;
   logic [7:0]  s_data;
   logic        s_last;
   logic        s_mem;
   logic        s_stat;
   logic [7:0]  mem_q;
   logic [31:0] wd_cnt;
   logic        drv_prev;
   logic        drv_pend;
   logic        fifo_ready;

   // Byte acceptance and segment tracking
   wire        take    = rx_valid && rx_ready;
   assign lim = (ps == PS_PRE)  ? `FBS_PRE_LEN   :
                (ps == PS_ETH)  ? `FBS_ETH_LEN   :
                (ps == PS_IP)   ? `FBS_IPUDP_LEN :
                (ps == PS_FBH)  ? `FBS_FBH_LEN   :
                (ps == PS_DGH)  ? `FBS_DGH_LEN   :
                (ps == PS_DATA) ? dlen           : `FBS_WKC_LEN;
   wire        seg_end = take && (ps != PS_TAIL) && (cnt == lim - 11'd1);
   wire [15:0] etype   = {etype_hi, rx_data};

   // Command decode
   wire auto_cmd = (cmd == `FBS_CMD_APRD) || (cmd == `FBS_CMD_APWR) || (cmd == `FBS_CMD_APRW);
   wire fix_cmd  = (cmd == `FBS_CMD_FPRD) || (cmd == `FBS_CMD_FPWR) || (cmd == `FBS_CMD_FPRW);
   wire rd_cmd   = (cmd == `FBS_CMD_APRD) || (cmd == `FBS_CMD_APRW) ||
                   (cmd == `FBS_CMD_FPRD) || (cmd == `FBS_CMD_FPRW);
   wire wr_cmd   = (cmd == `FBS_CMD_APWR) || (cmd == `FBS_CMD_APRW) ||
                   (cmd == `FBS_CMD_FPWR) || (cmd == `FBS_CMD_FPRW);
   wire [15:0] adp_full = {rx_data, adp_lo};

   // Data phase address decode and per-state gating
   wire [15:0] cur_addr = ado + {5'h00, cnt};
   wire [1:0]  sm       = cur_addr[8:7];
   wire        in_sm    = cur_addr[15:9] == `FBS_SM_PAGE;
   wire        mbx_on   = al_state != AL_INIT;
   wire        pdi_on   = (al_state == AL_SAFEOP) || (al_state == AL_OP);
   wire        op_on    = al_state == AL_OP;
   wire        d_on     = take && (ps == PS_DATA) && hit;
   wire        mem_rd   = d_on && rd_cmd && in_sm &&
                          ((sm == `FBS_SM_MBX_IN && mbx_on) || (sm == `FBS_SM_PD_IN && pdi_on));
   wire        mem_wr   = d_on && wr_cmd && in_sm &&
                          ((sm == `FBS_SM_MBX_OUT && mbx_on) || (sm == `FBS_SM_PD_OUT && op_on));
   wire        stat_rd  = d_on && rd_cmd && (cur_addr == `FBS_ADR_ALSTAT);
   wire        al_wr    = d_on && wr_cmd && (cur_addr == `FBS_ADR_ALCTL);
   wire        wd_refresh = mem_wr && (sm == `FBS_SM_PD_OUT);
   wire        wd_fire  = op_on && !wd_refresh && (wd_cnt == 32'(WD_CYCLES - 1));

   // Byte rewrite: position increment and working counter increment
   wire in_dgh   = take && (ps == PS_DGH);
   wire in_wkc   = take && (ps == PS_WKC);
   wire add_bit  = (in_dgh && auto_cmd && cnt == 11'd2) ||
                   (in_dgh && auto_cmd && cnt == 11'd3 && carry) ||
                   (in_wkc && cnt == 11'd0 && exch) ||
                   (in_wkc && cnt == 11'd1 && carry);
   wire [8:0] sum = {1'b0, rx_data} + {8'h00, add_bit};

   // State request handling: only legal steps, bootstrap refused
   function automatic fbs_al_t al_next(fbs_al_t cur, logic [7:0] req);
      fbs_al_t nxt;
      nxt = cur;
      if (req == `FBS_REQ_INIT) begin
         nxt = AL_INIT;
      end else if (req == `FBS_REQ_PREOP) begin
         nxt = AL_PREOP;
      end else if (req == `FBS_REQ_SAFEOP && cur != AL_INIT) begin
         nxt = AL_SAFEOP;
      end else if (req == `FBS_REQ_OP && (cur == AL_SAFEOP || cur == AL_OP)) begin
         nxt = AL_OP;
      end
      return nxt;
   endfunction
   wire fbs_al_t req_state = al_next(al_state, rx_data);
   wire [7:0] stat_byte = (al_state == AL_INIT)   ? `FBS_REQ_INIT   :
                          (al_state == AL_PREOP)  ? `FBS_REQ_PREOP  :
                          (al_state == AL_SAFEOP) ? `FBS_REQ_SAFEOP : `FBS_REQ_OP;

   // Parser sequencing
   always_comb begin
      next_ps = ps;
      unique case (ps)
         PS_PRE:  next_ps = PS_ETH;
         PS_ETH:  next_ps = (etype == `FBS_TYPE_RAW) ? PS_FBH :
                            (etype == `FBS_TYPE_IP) ? PS_IP : PS_TAIL;
         PS_IP:   next_ps = PS_FBH;
         PS_FBH:  next_ps = PS_DGH;
         PS_DGH:  next_ps = (dlen == 11'd0) ? PS_WKC : PS_DATA;
         PS_DATA: next_ps = PS_WKC;
         PS_WKC:  next_ps = more ? PS_DGH : PS_TAIL;
         PS_TAIL: next_ps = PS_TAIL;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         ps  <= PS_PRE;
         cnt <= '0;
      end else if (take && rx_last) begin
         ps  <= PS_PRE;
         cnt <= '0;
      end else if (take && rx_first) begin
         ps  <= PS_PRE;
         cnt <= 11'd1;
      end else if (seg_end) begin
         ps  <= next_ps;
         cnt <= '0;
      end else if (take) begin
         cnt <= cnt + 11'd1;
      end
   end

   // Header capture and addressing
   always_ff @(posedge core_clk) begin
      if (srst) begin
         etype_hi <= '0;
         cmd      <= '0;
         adp_lo   <= '0;
         ado      <= '0;
         dlen     <= '0;
         more     <= 1'b0;
         hit      <= 1'b0;
      end else begin
         if (take && ps == PS_ETH && cnt == 11'd12) begin
            etype_hi <= rx_data;
         end
         if (in_dgh) begin
            unique case (cnt)
               11'd0:   cmd <= rx_data;
               11'd2:   adp_lo <= rx_data;
               11'd3:   hit <= (auto_cmd && adp_full == 16'h0000) ||
                               (fix_cmd && adp_full == node_addr);
               11'd4:   ado[7:0] <= rx_data;
               11'd5:   ado[15:8] <= rx_data;
               11'd6:   dlen[7:0] <= rx_data;
               11'd7: begin
                  dlen[10:8] <= rx_data[2:0];
                  more       <= rx_data[7];
               end
               default: ;
            endcase
         end
      end
   end

   // Exchange tracking and working counter carry
   always_ff @(posedge core_clk) begin
      if (srst || (in_dgh && cnt == 11'd0)) begin
         exch   <= 1'b0;
         wr_mbx <= 1'b0;
         wr_pd  <= 1'b0;
         carry  <= 1'b0;
      end else begin
         exch   <= exch | mem_rd | mem_wr | stat_rd | al_wr;
         wr_mbx <= wr_mbx | (mem_wr && sm == `FBS_SM_MBX_OUT);
         wr_pd  <= wr_pd | wd_refresh;
         carry  <= add_bit ? sum[8] : (in_wkc ? 1'b0 : carry);
      end
   end

   // Completion events to the application
   always_ff @(posedge core_clk) begin
      if (srst) begin
         mbx_rx     <= 1'b0;
         out_update <= 1'b0;
      end else begin
         mbx_rx     <= in_wkc && cnt == 11'd1 && wr_mbx;
         out_update <= in_wkc && cnt == 11'd1 && wr_pd && op_on;
      end
   end

   // Output stage: one cycle behind the input, read data merged here
   always_ff @(posedge core_clk) begin
      if (srst) begin
         s_valid <= 1'b0;
         s_data  <= '0;
         s_last  <= 1'b0;
         s_mem   <= 1'b0;
         s_stat  <= 1'b0;
      end else begin
         s_valid <= take;
         s_data  <= sum[7:0];
         s_last  <= rx_last;
         s_mem   <= mem_rd;
         s_stat  <= stat_rd;
      end
   end
   wire [7:0] s_out = s_mem ? mem_q : (s_stat ? stat_byte : s_data);

   fbs_sm_mem u_mem (
      .core_clk (core_clk),
      .a_addr   (cur_addr[8:0]),
      .a_we     (mem_wr),
      .a_wdata  (rx_data),
      .a_rdata  (mem_q),
      .b_addr   (app_addr),
      .b_we     (app_we),
      .b_wdata  (app_wdata),
      .b_rdata  (app_rdata)
   );

   fbs_fifo #(
      .WIDTH (9),
      .DEPTH (`FBS_FIFO_DEPTH),
      .SLACK (`FBS_FIFO_SLACK)
   ) u_fifo (
      .core_clk  (core_clk),
      .srst      (srst),
      .in_data   ({s_last, s_out}),
      .in_valid  (s_valid),
      .in_ready  (fifo_ready),
      .out_data  ({tx_last, tx_data}),
      .out_valid (tx_valid),
      .out_ready (tx_ready)
   );
   assign rx_ready = fifo_ready;

   // Output watchdog, the only supervision of the master
   always_ff @(posedge core_clk) begin
      if (srst || !op_on || wd_refresh) begin
         wd_cnt <= '0;
      end else begin
         wd_cnt <= wd_cnt + 32'd1;
      end
   end

   // State machine
   always_ff @(posedge core_clk) begin
      if (srst) begin
         al_state <= AL_INIT;
      end else if (wd_fire) begin
         al_state <= AL_SAFEOP;
      end else if (al_wr) begin
         al_state <= req_state;
      end
   end

   // Fault reaction and emergency messages
   wire drv_req = (drive_fault && !drv_prev) || drv_pend;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         wd_timeout     <= 1'b0;
         motor_passive  <= 1'b0;
         motor_zero_vel <= 1'b0;
         drv_prev       <= 1'b0;
         drv_pend       <= 1'b0;
         emcy_valid     <= 1'b0;
         emcy_code      <= '0;
      end else begin
         drv_prev   <= drive_fault;
         drv_pend   <= drv_req && wd_fire;
         emcy_valid <= wd_fire || drv_req;
         emcy_code  <= wd_fire ? `FBS_EMCY_WD : `FBS_EMCY_DRV;
         if (wd_fire) begin
            wd_timeout     <= 1'b1;
            motor_passive  <= !fault_zero_vel;
            motor_zero_vel <= fault_zero_vel;
         end else if (al_wr && req_state == AL_OP) begin
            wd_timeout     <= 1'b0;
            motor_passive  <= 1'b0;
            motor_zero_vel <= 1'b0;
         end
      end
   end

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   wire chg_cause = al_wr || wd_fire;
   sequence s_wkc_first;
      in_wkc && cnt == 11'd0 && exch;
   endsequence
   sequence s_auto_pos;
      in_dgh && auto_cmd && cnt == 11'd2;
   endsequence
   property p_req_only;
      !$stable(al_state) |-> $past(chg_cause);
   endproperty
   a_req_only: assert property (p_req_only) else $error("state moved without request");
   property p_no_skip;
      al_wr && rx_data == `FBS_REQ_OP && al_state == AL_PREOP |=> al_state == AL_PREOP;
   endproperty
   a_no_skip: assert property (p_no_skip) else $error("preop jumped to op");
   property p_no_boot;
      al_wr && rx_data == `FBS_REQ_BOOT && !wd_fire |=> $stable(al_state);
   endproperty
   a_no_boot: assert property (p_no_boot) else $error("bootstrap request acted on");
   property p_wd_drop;
      wd_fire |=> al_state == AL_SAFEOP && wd_timeout ##1 wd_cnt == 32'd0;
   endproperty
   a_wd_drop: assert property (p_wd_drop) else $error("watchdog did not drop state");
   property p_reaction;
      wd_fire |=> (motor_zero_vel == $past(fault_zero_vel)) && (motor_passive != motor_zero_vel);
   endproperty
   a_reaction: assert property (p_reaction) else $error("wrong fault reaction");
   property p_emcy;
      wd_fire |=> emcy_valid && emcy_code == `FBS_EMCY_WD;
   endproperty
   a_emcy: assert property (p_emcy) else $error("no emergency on timeout");
   property p_init_quiet;
      al_state == AL_INIT |-> !mem_rd && !mem_wr;
   endproperty
   a_init_quiet: assert property (p_init_quiet) else $error("memory access in init");
   property p_no_out_wr;
      al_state != AL_OP |-> !(mem_wr && sm == `FBS_SM_PD_OUT);
   endproperty
   a_no_out_wr: assert property (p_no_out_wr) else $error("outputs taken outside op");
   property p_wkc_inc;
      s_wkc_first |=> s_data == 8'($past(rx_data) + 8'h01);
   endproperty
   a_wkc_inc: assert property (p_wkc_inc) else $error("counter not raised");
   property p_pos_inc;
      s_auto_pos |=> s_data == 8'($past(rx_data) + 8'h01);
   endproperty
   a_pos_inc: assert property (p_pos_inc) else $error("position not advanced");
   property p_fix_hit;
      in_dgh && cnt == 11'd3 && fix_cmd && adp_full == node_addr |=> hit;
   endproperty
   a_fix_hit: assert property (p_fix_hit) else $error("own address missed");
endmodule // fbs_slave_ctrl

// ### rtl/fbs_cfg.svh
// Constants of the fieldbus slave state control: frame layout, commands,
// address map, state request codes and timing.
// Assumes inclusion by bare name from the slave control module and the bench.
`ifndef FBS_CFG_SVH
`define FBS_CFG_SVH
// Frame segments, in bytes
`define FBS_PRE_LEN    11'd8
`define FBS_ETH_LEN    11'd14
`define FBS_IPUDP_LEN  11'd28
`define FBS_FBH_LEN    11'd2
`define FBS_DGH_LEN    11'd10
`define FBS_WKC_LEN    11'd2
// Ethernet type field values
`define FBS_TYPE_RAW   16'h88a4
`define FBS_TYPE_IP    16'h0800
// Datagram commands
`define FBS_CMD_APRD   8'h01
`define FBS_CMD_APWR   8'h02
`define FBS_CMD_APRW   8'h03
`define FBS_CMD_FPRD   8'h04
`define FBS_CMD_FPWR   8'h05
`define FBS_CMD_FPRW   8'h06
// Slave address map
`define FBS_ADR_ALCTL  16'h0120
`define FBS_ADR_ALSTAT 16'h0130
`define FBS_SM_PAGE    7'h08
`define FBS_SM_MBX_OUT 2'h0
`define FBS_SM_MBX_IN  2'h1
`define FBS_SM_PD_OUT  2'h2
`define FBS_SM_PD_IN   2'h3
// State request and status codes
`define FBS_REQ_INIT   8'h01
`define FBS_REQ_PREOP  8'h02
`define FBS_REQ_BOOT   8'h03
`define FBS_REQ_SAFEOP 8'h04
`define FBS_REQ_OP     8'h08
// Timing
`define FBS_CLK_KHZ    40000
`define FBS_WD_TIME_MS 100
// Emergency codes
`define FBS_EMCY_WD    16'h8130
`define FBS_EMCY_DRV   16'h1000
// Output buffer
`define FBS_FIFO_DEPTH 16
`define FBS_FIFO_SLACK 4
`endif

// ### rtl/fbs_pkg.sv
// Types of the fieldbus slave state control.
// Assumes nothing beyond the constants header.
package fbs_pkg;
   typedef enum logic [1:0] {
      AL_INIT   = 2'b00,
      AL_PREOP  = 2'b01,
      AL_SAFEOP = 2'b10,
      AL_OP     = 2'b11
   } fbs_al_t;
   typedef enum logic [2:0] {
      PS_PRE  = 3'b000,
      PS_ETH  = 3'b001,
      PS_IP   = 3'b010,
      PS_FBH  = 3'b011,
      PS_DGH  = 3'b100,
      PS_DATA = 3'b101,
      PS_WKC  = 3'b110,
      PS_TAIL = 3'b111
   } fbs_parse_t;
endpackage

// ### rtl/fbs_fifo.sv
// Output byte buffer with registered read side.
// Assumes one clock; in_ready signals room for SLACK more words.
`timescale 1ns/1ps
module fbs_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16,
   parameter int SLACK = 4
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             srst,
   // Fill side
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   // Drain side
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp;
   logic [AW-1:0]    rp;
   logic [AW:0]      level;
   logic [AW:0]      next_level;
   wire              full  = level == (AW+1)'(DEPTH);
   wire              empty = level == '0;
   wire              push  = in_valid && !full;
   wire              pop   = !empty && (!out_valid || out_ready);
   assign next_level = level + (AW+1)'(push) - (AW+1)'(pop);

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wp] <= in_data;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         wp        <= '0;
         rp        <= '0;
         level     <= '0;
         in_ready  <= 1'b0;
         out_valid <= 1'b0;
         out_data  <= '0;
      end else begin
         wp       <= push ? wp + 1'b1 : wp;
         rp       <= pop ? rp + 1'b1 : rp;
         level    <= next_level;
         in_ready <= next_level <= (AW+1)'(DEPTH - SLACK);
         if (pop) begin
            out_data  <= mem[rp];
            out_valid <= 1'b1;
         end else if (out_ready) begin
            out_valid <= 1'b0;
         end
      end
   end
endmodule // fbs_fifo

// ### rtl/fbs_sm_mem.sv
// Sync manager application memory, four windows of 128 bytes.
// Port a faces the frame, port b the application; both reads registered.
`timescale 1ns/1ps
module fbs_sm_mem (
   // Clock
   input  wire logic       core_clk,
   // Frame side
   input  wire logic [8:0] a_addr,
   input  wire logic       a_we,
   input  wire logic [7:0] a_wdata,
   output logic [7:0]      a_rdata,
   // Application side
   input  wire logic [8:0] b_addr,
   input  wire logic       b_we,
   input  wire logic [7:0] b_wdata,
   output logic [7:0]      b_rdata
);
   logic [7:0] mem [512];

   // Frame write wins over an application write to the same byte
   always_ff @(posedge core_clk) begin
      if (b_we) begin
         mem[b_addr] <= b_wdata;
      end
      if (a_we) begin
         mem[a_addr] <= a_wdata;
      end
      a_rdata <= mem[a_addr];
      b_rdata <= mem[b_addr];
   end
endmodule // fbs_sm_mem

// ### tb/fbs_master_model.sv
// Master model: sends frames byte by byte, collects bytes forwarded by the slave.
// Assumes one clock; the bench supplies frames and the sink stall mode.
`timescale 1ns/1ps
module fbs_master_model (
   // Clock
   input  wire logic       core_clk,
   // Frame toward slave
   output logic [7:0]      rx_data,
   output logic            rx_valid,
   output logic            rx_first,
   output logic            rx_last,
   input  wire logic       rx_ready,
   // Frame from slave
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_last,
   input  wire logic       tx_valid,
   output logic            tx_ready
);
   logic [7:0] got[$];
   logic       done = 1'b0;
   int         stall = 0;
   int         n = 0;
   initial begin
      rx_data = 8'h00;
      rx_valid = 1'b0;
      rx_first = 1'b0;
      rx_last = 1'b0;
      tx_ready = 1'b1;
   end
   // One frame at a time, each byte held until taken
   task automatic send(input logic [7:0] f[$]);
      for (int i = 0; i < f.size(); i++) begin
         rx_data = f[i];
         rx_valid = 1'b1;
         rx_first = (i == 0);
         rx_last = (i == f.size() - 1);
         @(posedge core_clk);
         while (rx_ready !== 1'b1) @(posedge core_clk);
         #2;
      end
      rx_valid = 1'b0;
      rx_first = 1'b0;
      rx_last = 1'b0;
      rx_data = ~rx_data;
   endtask
   // Sink ready always, every other cycle, or never
   always @(posedge core_clk) begin
      n++;
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
         got.push_back(tx_data);
         done = tx_last;
      end
      tx_ready <= #2 (stall == 0) || (stall == 1 && n[0]);
   end
endmodule // fbs_master_model

// ### tb/test_fbs_slave_ctrl.sv
// Bench of the slave state control, driven through the master model.
// Assumes a 40 MHz core_clk and a watchdog shortened to 100 cycles.
`timescale 1ns/1ps
`include "fbs_cfg.svh"
module test_fbs_slave_ctrl;
   import fbs_pkg::*;
   localparam logic [15:0] NODE = 16'h0a05;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] rx_data, tx_data, app_wdata, app_rdata;
   logic rx_valid, rx_first, rx_last, rx_ready, tx_last, tx_valid, tx_ready;
   logic [15:0] node_addr, emcy_code, code;
   logic [8:0] app_addr;
   logic app_we, fault_zero_vel, drive_fault, motor_passive, motor_zero_vel;
   logic wd_timeout, emcy_valid, out_update, mbx_rx;
   fbs_al_t al_state;
   logic [7:0] frm[$];
   int num_errors = 0;
   int checks = 0;
   int n_mbx = 0, n_out = 0, n_emcy = 0, cyc = 0, off = 0;

   fbs_slave_ctrl #(.WD_CYCLES(100)) i_fbs_slave_ctrl (.core_clk, .srst, .rx_data,
      .rx_valid, .rx_first, .rx_last, .rx_ready, .tx_data, .tx_last, .tx_valid,
      .tx_ready, .node_addr, .app_addr, .app_we, .app_wdata, .app_rdata,
      .fault_zero_vel, .drive_fault, .motor_passive, .motor_zero_vel, .wd_timeout,
      .emcy_valid, .emcy_code, .out_update, .mbx_rx, .al_state);
   fbs_master_model i_fbs_master_model (.core_clk, .rx_data, .rx_valid, .rx_first,
      .rx_last, .rx_ready, .tx_data, .tx_last, .tx_valid, .tx_ready);

   always #12.5 core_clk = ~core_clk;
   // Event counters and run limit
   always @(posedge core_clk) begin
      cyc++;
      if (mbx_rx === 1'b1) n_mbx++;
      if (out_update === 1'b1) n_out++;
      if (emcy_valid === 1'b1) begin
         n_emcy++;
         code = emcy_code;
      end
      if (cyc == 20000) begin
         num_errors++;
         conclude();
      end
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checks++;
      if (g !== e) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
         num_errors++;
      end
   endtask
   task automatic conclude();
      $display("checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic bounded(input int lim);
      for (int k = 0; k < lim && i_fbs_master_model.done !== 1'b1; k++) @(posedge core_clk);
      #2;
   endtask
   task automatic start();
      i_fbs_master_model.got = {};
      i_fbs_master_model.done = 1'b0;
      fork
         i_fbs_master_model.send(frm);
      join_none
   endtask
   // Byte i of the forwarded datagram
   function automatic logic [7:0] ob(input int i);
      return i_fbs_master_model.got[24 + off + i];
   endfunction
   // One frame, one datagram of one data byte
   task automatic dg(input logic [7:0] c, input logic [15:0] p, a, input logic [7:0] d,
                     input bit ip = 1'b0);
      off = ip ? 28 : 0;
      frm = {8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'hd5};
      for (int i = 0; i < 12; i++) frm.push_back(8'h20 + 8'(i));
      frm = {frm, (ip ? 8'h08 : 8'h88), (ip ? 8'h00 : 8'ha4)};
      for (int i = 0; i < off; i++) frm.push_back(8'h45);
      frm = {frm, 8'h0b, 8'h10, c, 8'h00, p[7:0], p[15:8], a[7:0], a[15:8], 8'h01};
      frm = {frm, 8'h00, 8'h00, 8'h00, d, 8'h00, 8'h00, 8'hc3, 8'h5a, 8'h0f, 8'he1};
      start();
      bounded(300);
      chk(16'(i_fbs_master_model.got.size()), 16'(frm.size()));
   endtask
   task automatic req(input logic [7:0] r, input fbs_al_t s);
      dg(`FBS_CMD_FPWR, NODE, `FBS_ADR_ALCTL, r);
      chk(16'(al_state), 16'(s));
   endtask
   task automatic app(input logic [8:0] a, input logic [7:0] w, input logic we);
      app_addr = a;
      app_wdata = w;
      app_we = we;
      @(posedge core_clk);
      #2;
      app_we = 1'b0;
      @(posedge core_clk);
      #2;
   endtask
   task automatic wait_wd();
      for (int k = 0; k < 300 && wd_timeout !== 1'b1; k++) @(posedge core_clk);
      #2;
      chk(16'(al_state), 16'(AL_SAFEOP));
      chk(code, `FBS_EMCY_WD);
   endtask

   initial begin
      node_addr = NODE;
      app_addr = 9'h000;
      app_we = 1'b0;
      app_wdata = 8'h00;
      fault_zero_vel = 1'b1;
      drive_fault = 1'b0;
      repeat (6) @(posedge core_clk);
      #2;
      srst = 1'b0;
      chk({al_state, wd_timeout, motor_passive, emcy_valid}, 16'h0);
      dg(`FBS_CMD_FPWR, NODE + 16'h1, `FBS_ADR_ALCTL, `FBS_REQ_PREOP);
      chk(16'(al_state), 16'(AL_INIT));
      chk(ob(11), 8'h00);
      req(`FBS_REQ_OP, AL_INIT);
      req(`FBS_REQ_SAFEOP, AL_INIT);
      req(`FBS_REQ_BOOT, AL_INIT);
      dg(`FBS_CMD_FPWR, NODE, 16'h1000, 8'h5a);
      chk({ob(11), 8'(n_mbx)}, 16'h0);
      dg(`FBS_CMD_FPRD, NODE, 16'h1080, 8'h66);
      chk(ob(10), 8'h66);
      req(`FBS_REQ_PREOP, AL_PREOP);
      chk(ob(11), 8'h01);
      req(`FBS_REQ_OP, AL_PREOP);
      dg(`FBS_CMD_FPWR, NODE, 16'h1000, 8'ha5);
      chk(16'(n_mbx), 16'h1);
      app(9'h000, 8'h00, 1'b0);
      chk(app_rdata, 8'ha5);
      dg(`FBS_CMD_FPWR, NODE, 16'h1100, 8'h11);
      chk(ob(11), 8'h00);
      req(`FBS_REQ_SAFEOP, AL_SAFEOP);
      app(9'h180, 8'h3c, 1'b1);
      dg(`FBS_CMD_APRD, 16'h0000, 16'h1180, 8'h00);
      chk({ob(10), ob(2)}, 16'h3c01);
      chk(ob(11), 8'h01);
      dg(`FBS_CMD_APRD, 16'hffff, 16'h1180, 8'h77);
      chk({ob(10), ob(2)}, 16'h7700);
      chk({ob(3), ob(11)}, 16'h0000);
      dg(`FBS_CMD_FPWR, NODE, 16'h1100, 8'h22);
      chk({ob(11), 8'(n_out)}, 16'h0);
      dg(`FBS_CMD_APRW, 16'h0000, 16'h1100, 8'h44);
      chk({ob(10), ob(11)}, 16'h4400);
      req(`FBS_REQ_OP, AL_OP);
      dg(`FBS_CMD_FPWR, NODE, 16'h1100, 8'h96);
      chk(16'(n_out), 16'h1);
      dg(`FBS_CMD_APWR, 16'h0000, 16'h1101, 8'hc7);
      chk({ob(11), 8'(n_out)}, 16'h0102);
      dg(`FBS_CMD_FPRW, NODE, 16'h1180, 8'h00);
      chk({ob(10), ob(11)}, 16'h3c01);
      app(9'h100, 8'h00, 1'b0);
      chk(app_rdata, 8'h96);
      wait_wd();
      chk({motor_zero_vel, motor_passive}, 16'h2);
      fault_zero_vel = 1'b0;
      req(`FBS_REQ_OP, AL_OP);
      chk({wd_timeout, motor_zero_vel}, 16'h0);
      wait_wd();
      chk({motor_zero_vel, motor_passive}, 16'h1);
      drive_fault = 1'b1;
      repeat (3) @(posedge core_clk);
      #2;
      chk(code, `FBS_EMCY_DRV);
      chk(16'(n_emcy), 16'h3);
      dg(`FBS_CMD_FPRD, NODE, `FBS_ADR_ALSTAT, 8'h00, 1'b1);
      chk(ob(10), `FBS_REQ_SAFEOP);
      i_fbs_master_model.stall = 2;
      frm = {};
      for (int i = 0; i < 40; i++) frm.push_back(8'(i));
      start();
      repeat (30) @(posedge core_clk);
      #2;
      chk(rx_ready, 1'b0);
      i_fbs_master_model.stall = 1;
      bounded(300);
      chk(16'(i_fbs_master_model.got.size()), 16'd40);
      for (int i = 0; i < 40; i++) chk(i_fbs_master_model.got[i], 16'(i));
      conclude();
   end
endmodule // test_fbs_slave_ctrl
